// [rtl/cmp_monitor_pkg.sv]
// Shared constants for the analog comparator monitor controller
package cmp_monitor_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets (one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [5:0] OFS_CONTROL_STATUS = 6'h00; // Start and flags
  localparam logic [5:0] OFS_CONFIGURATION  = 6'h04; // Mode, enables
  localparam logic [5:0] OFS_TIMING         = 6'h08; // Delay, divider
  localparam logic [5:0] OFS_THRESHOLD      = 6'h0c; // Threshold value
  localparam logic [5:0] OFS_COMPARE_RESULT = 6'h10; // Compare bits
  localparam logic [5:0] OFS_LEVEL_BASE     = 6'h20; // Level data 0..7

  // ------------------------------------------------------------------
  // Control and status field positions
  // ------------------------------------------------------------------
  localparam int BIT_START        = 0;
  localparam int BIT_END_MEASURE  = 1;
  localparam int BIT_END_COMPARE  = 2;
  localparam int BIT_BEYOND       = 3;

  // ------------------------------------------------------------------
  // Configuration field positions
  // ------------------------------------------------------------------
  localparam int POS_MODE_LO      = 0;
  localparam int BIT_MEASURE_IEN  = 3;
  localparam int BIT_THRESH_IEN   = 4;
  localparam int BIT_OVER_UNDER   = 5;

  // ------------------------------------------------------------------
  // Timing field positions and widths
  // ------------------------------------------------------------------
  localparam int POS_DELAY        = 0;
  localparam int WID_DELAY        = 4;
  localparam int POS_DIVIDER      = 4;
  localparam int WID_DIVIDER      = 4;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] RST_DELAY     = 4'hf; // Slowest sampling
  localparam logic [3:0] RST_DIVIDER   = 4'hf; // Slowest trigger rate
  localparam logic [5:0] RST_THRESHOLD = 6'h00;

  // ------------------------------------------------------------------
  // Operating modes and sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_LEVEL   = 2'b01,
    MODE_COMPARE = 2'b10,
    MODE_LOWPWR  = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_WAIT   = 2'b11
  } state_t;

endpackage

// [rtl/analog_comparator_monitor_ctrl.sv]
// Analog comparator monitor controller with Wishbone register slave
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps

module analog_comparator_monitor_ctrl
  import cmp_monitor_pkg::*;
#(
  parameter int NUM_INPUTS = 8,
  parameter int LEVEL_BITS = 6
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [5:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [NUM_INPUTS-1:0] analog_input_i,
  output logic      [LEVEL_BITS-1:0] dac_value_o,
  output logic                       comparator_enable_o,
  input  wire logic                  low_rate_trigger_i,
  output logic                       irq_interrupt_controller_o,
  output logic                       irq_wakeup_unit_o
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (NUM_INPUTS != 8 || LEVEL_BITS != 6) begin : g_bad_param
    $error("Monitor supports eight inputs of six-bit level only");
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  mode_t                 monitor_mode_field;   // Configured mode
  mode_t                 active_mode;          // Mode in use
  logic                  measure_irq_enable;   // Mask for end of measure
  logic                  threshold_irq_enable; // Mask for beyond flag
  logic                  over_under_select;    // 1 above, 0 below
  logic [WID_DELAY-1:0]  sample_delay_field;   // Settle cycles
  logic [WID_DIVIDER-1:0] trigger_divider_field; // Trigger divisor
  logic [5:0]            threshold_value;      // Compare level
  logic                  end_of_measure_flag;  // Level burst done
  logic                  end_of_compare_flag;  // Compare burst done
  logic                  beyond_threshold_flag; // Low-power event
  logic [7:0]            compare_bit;          // Compare results
  logic [5:0]            level_value [8];      // Level buffers
  state_t                state;                // Sequencer state
  logic [5:0]            ramp;                 // Converter code
  logic [WID_DELAY-1:0]  delay_cnt;            // Settle countdown
  logic [WID_DIVIDER-1:0] div_cnt;             // Trigger prescaler
  logic [7:0]            cmp_meta;             // Sync stage one
  logic [7:0]            cmp_sync;             // Sync stage two
  logic [7:0]            cmp_seen;             // Inputs latched in ramp
  logic [1:0]            trig_sync;            // Trigger synchroniser
  logic                  trig_last;            // Trigger edge memory
  logic                  ack;                  // Bus answer

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // Classic single-cycle slave: a request is taken only while ack is
  // low, so a strobe still held after the answer is not taken twice.
  // Every address answers; unmapped ones read zero, drop writes.
  wire       bus_req    = wb_cyc_i & wb_stb_i & ~ack;
  wire       wr_lane0   = bus_req & wb_we_i & wb_sel_i[0];
  wire       hit_cts    = wb_adr_i == OFS_CONTROL_STATUS;
  wire       hit_cnf    = wb_adr_i == OFS_CONFIGURATION;
  wire       hit_tim    = wb_adr_i == OFS_TIMING;
  wire       hit_thr    = wb_adr_i == OFS_THRESHOLD;
  wire       hit_res    = wb_adr_i == OFS_COMPARE_RESULT;
  wire       hit_lvl    = wb_adr_i[5] & (wb_adr_i[1:0] == 2'b00);
  wire [2:0] lvl_idx    = wb_adr_i[4:2];
  wire [7:0] wd         = wb_dat_i[7:0];
  wire       wr_cts     = wr_lane0 & hit_cts;
  wire       wr_cnf     = wr_lane0 & hit_cnf;
  wire       wr_tim     = wr_lane0 & hit_tim;
  wire       wr_thr     = wr_lane0 & hit_thr;

  // Start only acts when the requested mode differs from the one in use
  wire       start_req  = wr_cts & wd[BIT_START];
  wire       start_go   = start_req &
                          (monitor_mode_field != active_mode);

  // The divider restarts at zero on a start, so the first trigger edge
  // after a start fires at once; later ones fire on every
  // (divider+1)-th edge.
  // Synchronised trigger rising edge and divided trigger
  wire       trig_edge  = trig_sync[1] & ~trig_last;
  wire       trig_fire  = trig_edge & (div_cnt == '0);

  // The synchroniser costs two cycles; the settle count must cover
  // them on top of converter and comparator delay.
  // Comparator high means input above the converter level
  wire [7:0] above      = cmp_sync;
  wire       any_beyond = over_under_select ? |above : |(~above);

  // Flag set requests, each valid only in its own mode, so a sample
  // in one mode never touches another mode's flag.
  wire       sample_now = (state == ST_SAMPLE);
  wire       set_eom    = sample_now & (active_mode == MODE_LEVEL) &
                          (ramp == 6'h3f);
  wire       set_eoc    = sample_now & (active_mode == MODE_COMPARE);
  wire       set_beyond = sample_now & (active_mode == MODE_LOWPWR) &
                          any_beyond;

  // Read multiplexer, reserved bits read zero
  // Only the low byte carries data; start is write-only, reads zero.
  // Level buffers read back undefined until a ramp has filled them.
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_cts) begin
      rd_byte = {4'h0, beyond_threshold_flag, end_of_compare_flag,
                 end_of_measure_flag, 1'b0};
    end else if (hit_cnf) begin
      rd_byte = {2'b00, over_under_select, threshold_irq_enable,
                 measure_irq_enable, 1'b0, monitor_mode_field};
    end else if (hit_tim) begin
      rd_byte = {trigger_divider_field, sample_delay_field};
    end else if (hit_thr) begin
      rd_byte = {2'b00, threshold_value};
    end else if (hit_res) begin
      rd_byte = compare_bit;
    end else if (hit_lvl) begin
      rd_byte = {2'b00, level_value[lvl_idx]};
    end
  end

  // ------------------------------------------------------------------
  // Bus answer: ack one cycle after request, unmapped reads zero
  // ------------------------------------------------------------------
  // Read data is registered with the answer so it stands in the ack
  // cycle; the master takes it at the edge that samples ack high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack      <= bus_req;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end
  assign wb_ack_o = ack;

  // ------------------------------------------------------------------
  // Configuration registers, written only while idle by convention
  // ------------------------------------------------------------------
  // Writes land at the edge that takes the request, the same edge
  // that raises the answer; only byte lane zero is looked at.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      monitor_mode_field    <= MODE_OFF;
      measure_irq_enable    <= 1'b0;
      threshold_irq_enable  <= 1'b0;
      over_under_select     <= 1'b0;
      sample_delay_field    <= RST_DELAY;
      trigger_divider_field <= RST_DIVIDER;
      threshold_value       <= RST_THRESHOLD;
    end else begin
      // Changing these mid-operation is unpredictable; not guarded
      if (wr_cnf) begin
        monitor_mode_field   <= mode_t'(wd[POS_MODE_LO +: 2]);
        measure_irq_enable   <= wd[BIT_MEASURE_IEN];
        threshold_irq_enable <= wd[BIT_THRESH_IEN];
        over_under_select    <= wd[BIT_OVER_UNDER];
      end
      if (wr_tim) begin
        sample_delay_field    <= wd[POS_DELAY +: WID_DELAY];
        trigger_divider_field <= wd[POS_DIVIDER +: WID_DIVIDER];
      end
      if (wr_thr) begin
        threshold_value <= wd[5:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Event flags: hardware set wins over software clear
  // ------------------------------------------------------------------
  // Priority: start clear, then hardware set, then software clear.
  // Letting the set win keeps an event that meets a clear from being
  // lost; the start wins because it opens a fresh run.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      end_of_measure_flag   <= 1'b0;
      end_of_compare_flag   <= 1'b0;
      beyond_threshold_flag <= 1'b0;
    end else if (start_go) begin
      end_of_measure_flag   <= 1'b0;
      end_of_compare_flag   <= 1'b0;
      beyond_threshold_flag <= 1'b0;
    end else begin
      if (set_eom) begin
        end_of_measure_flag <= 1'b1;
      end else if (wr_cts & wd[BIT_END_MEASURE]) begin
        end_of_measure_flag <= 1'b0;
      end
      if (set_eoc) begin
        end_of_compare_flag <= 1'b1;
      end else if (wr_cts & wd[BIT_END_COMPARE]) begin
        end_of_compare_flag <= 1'b0;
      end
      if (set_beyond) begin
        beyond_threshold_flag <= 1'b1;
      end else if (wr_cts & wd[BIT_BEYOND]) begin
        beyond_threshold_flag <= 1'b0;
      end
    end
  end

  // Level output with no stretching: it drops the cycle after software
  // clears the causing flag or its enable.
  // Single level interrupt; end of compare has no enable
  wire monitor_irq = (end_of_measure_flag & measure_irq_enable) |
                     (beyond_threshold_flag & threshold_irq_enable);
  assign irq_interrupt_controller_o = monitor_irq;
  assign irq_wakeup_unit_o          = monitor_irq;

  // ------------------------------------------------------------------
  // Input synchronisers for comparators and trigger
  // ------------------------------------------------------------------
  // Both inputs are asynchronous to the core clock. Only the second
  // stage feeds logic; the first may go metastable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_meta  <= 8'h00;
      cmp_sync  <= 8'h00;
      trig_sync <= 2'b00;
      trig_last <= 1'b0;
    end else begin
      cmp_meta  <= analog_input_i;
      cmp_sync  <= cmp_meta;
      trig_sync <= {trig_sync[0], low_rate_trigger_i};
      trig_last <= trig_sync[1];
    end
  end

  // ------------------------------------------------------------------
  // Low-rate trigger prescaler, counts trigger edges
  // ------------------------------------------------------------------
  // Counts synchronised edges only; a start restarts it at zero.
  always_ff @(posedge clk_i) begin
    if (rst_i || start_go) begin
      div_cnt <= '0;
    end else if (trig_edge) begin
      div_cnt <= (div_cnt == trigger_divider_field) ? '0 : div_cnt + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer: load converter, settle, sample, step or wait
  // ------------------------------------------------------------------
  // Level mode walks the converter 0 to 63, one settle and one sample
  // per code. Compare mode samples once at the threshold. Low-power
  // mode waits for a divided trigger and returns to waiting.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= ST_IDLE;
      active_mode <= MODE_OFF;
      ramp        <= 6'h00;
      delay_cnt   <= '0;
    end else if (start_go) begin
      active_mode <= monitor_mode_field;
      ramp        <= (monitor_mode_field == MODE_LEVEL) ? 6'h00
                                                        : threshold_value;
      delay_cnt   <= sample_delay_field;
      case (monitor_mode_field)
        MODE_LEVEL, MODE_COMPARE: state <= ST_SETTLE;
        MODE_LOWPWR:              state <= ST_WAIT;
        default:                  state <= ST_IDLE;
      endcase
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_SETTLE: begin
          // Settle count covers converter and comparator delay
          if (delay_cnt == '0) begin
            state <= ST_SAMPLE;
          end else begin
            delay_cnt <= delay_cnt - 1'b1;
          end
        end
        ST_SAMPLE: begin
          delay_cnt <= sample_delay_field;
          if (active_mode == MODE_LEVEL && ramp != 6'h3f) begin
            ramp  <= ramp + 6'h01;
            state <= ST_SETTLE;
          end else if (active_mode == MODE_LOWPWR) begin
            state <= ST_WAIT;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (trig_fire) begin
            ramp  <= threshold_value;
            state <= ST_SETTLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign dac_value_o         = ramp;
  assign comparator_enable_o = (active_mode != MODE_OFF);

  // ------------------------------------------------------------------
  // Result buffers: no reset, undefined until first written
  // ------------------------------------------------------------------
  // Marks inputs already latched in this ramp, so only the first code
  // at which a comparator reads low is kept.
  always_ff @(posedge clk_i) begin
    if (rst_i || start_go) begin
      cmp_seen <= 8'h00;
    end else if (sample_now && active_mode == MODE_LEVEL) begin
      cmp_seen <= cmp_seen | ~above;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_level
    // Latch ramp code when the input first drops below the ramp
    always_ff @(posedge clk_i) begin
      if (sample_now && active_mode == MODE_LEVEL) begin
        if (!above[i] && !cmp_seen[i]) begin
          level_value[i] <= ramp;
        end else if (ramp == 6'h3f && !cmp_seen[i] && above[i]) begin
          level_value[i] <= 6'h3f;
        end
      end
    end
  end

  // Compare and low-power samples both refresh the result register
  always_ff @(posedge clk_i) begin
    if (sample_now && active_mode != MODE_LEVEL) begin
      compare_bit <= above;
    end
  end

endmodule

// [tb/cmp_monitor_asserts.sv]
// Port-level assertion checker for the comparator monitor controller
`timescale 1ns/100ps

module cmp_monitor_asserts
  import cmp_monitor_pkg::*;
#(
  parameter int NUM_INPUTS = 8,
  parameter int LEVEL_BITS = 6
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [5:0]            wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic [NUM_INPUTS-1:0] analog_input_i,
  input wire logic [LEVEL_BITS-1:0] dac_value_o,
  input wire logic                  comparator_enable_o,
  input wire logic                  low_rate_trigger_i,
  input wire logic                  irq_interrupt_controller_o,
  input wire logic                  irq_wakeup_unit_o
);
  // ------------------------------------------------------------------
  // Bus decode helpers
  // ------------------------------------------------------------------
  wire logic taken = wb_cyc_i && wb_stb_i && !wb_ack_o; // Accepted
  wire logic wr_ok = taken && wb_we_i && wb_sel_i[0];   // Effective write

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Write of ones to all three flag positions
  sequence s_flag_wipe;
    wr_ok && wb_adr_i == OFS_CONTROL_STATUS && wb_dat_i[3:1] == 3'b111;
  endsequence
  // Answer to a read of control and status
  sequence s_ctrl_read;
    $past(taken && !wb_we_i && wb_adr_i == OFS_CONTROL_STATUS) && wb_ack_o;
  endsequence

  // Reset must quiet outputs whatever came before, so no disable here
  property p_rst_quiet;
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> !wb_ack_o && !irq_interrupt_controller_o &&
              !comparator_enable_o && dac_value_o == '0;
  endproperty

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  AST_IRQ_TWIN: assert property (
    irq_interrupt_controller_o == irq_wakeup_unit_o)
    else $error("Interrupt copies differ");
  AST_ACK_NEXT: assert property (taken |=> wb_ack_o)
    else $error("Request not answered next cycle");
  AST_ACK_CAUSE: assert property (!taken |=> !wb_ack_o)
    else $error("Acknowledge without request");
  AST_DATA_HIGH: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("Upper read data not zero");
  AST_RST_QUIET: assert property (p_rst_quiet)
    else $error("Outputs active after reset");
  AST_W1C_ALL: assert property (
    s_flag_wipe |=> !irq_interrupt_controller_o)
    else $error("Interrupt survives flag clear");
  AST_IRQ_HOLD: assert property (
    $fell(irq_interrupt_controller_o) |-> $past(wr_ok &&
      (wb_adr_i == OFS_CONTROL_STATUS || wb_adr_i == OFS_CONFIGURATION)))
    else $error("Interrupt dropped without software action");
  AST_START_READ0: assert property (
    s_ctrl_read |-> wb_dat_o[BIT_START] == 1'b0)
    else $error("Start bit reads back set");
endmodule

bind analog_comparator_monitor_ctrl cmp_monitor_asserts #(
  .NUM_INPUTS(NUM_INPUTS),
  .LEVEL_BITS(LEVEL_BITS)
) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .analog_input_i(analog_input_i), .dac_value_o(dac_value_o),
  .comparator_enable_o(comparator_enable_o),
  .low_rate_trigger_i(low_rate_trigger_i),
  .irq_interrupt_controller_o(irq_interrupt_controller_o),
  .irq_wakeup_unit_o(irq_wakeup_unit_o)
);

// [tb/cmp_bank_model.sv]
// Behavioural comparator bank facing the monitor's converter
`timescale 1ns/100ps

module cmp_bank_model #(
  parameter int NUM_INPUTS = 8,
  parameter int LEVEL_BITS = 6,
  parameter bit SLOW       = 1'b0  // One cycle of comparator lag
) (
  input  wire logic                             clk_i,
  input  wire logic                             enable_i,
  input  wire logic [LEVEL_BITS-1:0]            dac_i,
  input  wire logic [NUM_INPUTS*LEVEL_BITS-1:0] level_i,
  output logic      [NUM_INPUTS-1:0]            cmp_o
);
  logic [NUM_INPUTS-1:0] raw;        // Ideal comparator decisions
  logic [NUM_INPUTS-1:0] lag = '0;   // Delayed or scrambled copy

  // High when the input stands above the converter level
  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      raw[i] = level_i[i*LEVEL_BITS +: LEVEL_BITS] > dac_i;
    end
  end

  // Disabled comparators toggle so stale values never look valid
  always_ff @(posedge clk_i) begin
    lag <= enable_i ? raw : ~lag;
  end

  assign cmp_o = (SLOW || !enable_i) ? lag : raw;
endmodule

// [tb/analog_comparator_monitor_ctrl_test.sv]
// Self-checking bench for the comparator monitor controller
`timescale 1ns/100ps

module analog_comparator_monitor_ctrl_test;
  import cmp_monitor_pkg::*;
  logic        clk  = 1'b0;  // 50 MHz core clock
  logic        rst  = 1'b1;  // Held for three cycles
  logic        req  = 1'b0;  // Drives both cyc and stb
  logic        we   = 1'b0;  // Bus direction
  logic [5:0]  adr  = '0;    // Byte address
  logic [31:0] wdat = '0;    // Write data
  logic        trig = 1'b0;  // Low-rate trigger
  logic [47:0] lvls = {6'h3e, 6'h08, 6'h11, 6'h20, 6'h01, 6'h00, 6'h2d, 6'h3f};
  logic [31:0] dat_o, rd;
  logic [7:0]  ain;
  logic [5:0]  dac;
  logic        ack, en, irq_ic, irq_wk;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;

  always #10 clk = ~clk;

  analog_comparator_monitor_ctrl uut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .analog_input_i(ain), .dac_value_o(dac),
    .comparator_enable_o(en), .low_rate_trigger_i(trig),
    .irq_interrupt_controller_o(irq_ic), .irq_wakeup_unit_o(irq_wk));

  // Slow comparators stress the sampling delay
  cmp_bank_model #(.SLOW(1'b1)) u_bank (
    .clk_i(clk), .enable_i(en), .dac_i(dac), .level_i(lvls), .cmp_o(ain));

  // ------------------------------------------------------------------
  // Reporting and bus tasks
  // ------------------------------------------------------------------
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then release
  task xfer(input logic [5:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    // No local limit: only the global hang guard ends this wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat_o;
    req <= 1'b0;
  endtask

  task wr(input logic [5:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rdc(input logic [5:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(rd, exp);
  endtask

  // Poll control and status until a flag shows, bounded
  task poll(input int b);
    int n;
    n = 0;
    do begin
      xfer(OFS_CONTROL_STATUS, 1'b0, 8'h00);
      n++;
    end while (rd[b] !== 1'b1 && n < 60);
  endtask

  task pulse;
    trig <= 1'b1;
    repeat (3) @(posedge clk);
    trig <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_reset;
    rdc(OFS_CONTROL_STATUS, 32'h0);
    rdc(OFS_CONFIGURATION, 32'h0);
    rdc(OFS_TIMING, 32'hff);
    rdc(OFS_THRESHOLD, 32'h0);
    rdc(6'h14, 32'h0);
    wr(OFS_THRESHOLD, 8'hea);
    rdc(OFS_THRESHOLD, 32'h2a);
  endtask

  task t_level;
    int n;
    n = 0;
    wr(OFS_TIMING, 8'h05);
    wr(OFS_CONFIGURATION, 8'h09);
    wr(OFS_CONTROL_STATUS, 8'h01);
    chk(32'(en), 32'h1);
    while (irq_ic !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(irq_wk), 32'h1);
    rdc(OFS_CONTROL_STATUS, 32'h2);
    for (int i = 0; i < 8; i++) begin
      rdc(OFS_LEVEL_BASE + 6'(4 * i), 32'(lvls[i*6 +: 6]));
    end
    wr(OFS_LEVEL_BASE, 8'h15);
    rdc(OFS_LEVEL_BASE, 32'(lvls[5:0]));
    wr(OFS_CONFIGURATION, 8'h01);
    chk(32'(irq_ic), 32'h0);
    wr(OFS_CONTROL_STATUS, 8'h00);
    rdc(OFS_CONTROL_STATUS, 32'h2);
  endtask

  // End-of-measure flag is left set so the start must wipe it
  task t_compare;
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      e[i] = lvls[i*6 +: 6] > 6'h11;
    end
    wr(OFS_THRESHOLD, 8'h11);
    wr(OFS_CONFIGURATION, 8'h0a);
    wr(OFS_CONTROL_STATUS, 8'h01);
    chk(32'(dac), 32'h11);
    xfer(OFS_CONTROL_STATUS, 1'b0, 8'h00);
    chk(32'(rd[1]), 32'h0);
    poll(2);
    chk(32'(rd[2]), 32'h1);
    chk(32'(irq_ic), 32'h0);
    rdc(OFS_COMPARE_RESULT, 32'(e));
    wr(OFS_CONTROL_STATUS, 8'h04);
    rdc(OFS_CONTROL_STATUS, 32'h0);
  endtask

  // Divider starts at zero: first edge fires, second is divided away
  task t_lowpower;
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      e[i] = lvls[i*6 +: 6] > 6'h1e;
    end
    wr(OFS_TIMING, 8'h15);
    wr(OFS_THRESHOLD, 8'h1e);
    wr(OFS_CONFIGURATION, 8'h33);
    wr(OFS_CONTROL_STATUS, 8'h01);
    pulse;
    poll(3);
    chk(rd, 32'h8);
    chk(32'(irq_wk), 32'h1);
    rdc(OFS_COMPARE_RESULT, 32'(e));
    wr(OFS_CONTROL_STATUS, 8'h08);
    chk(32'(irq_ic), 32'h0);
    pulse;
    repeat (40) @(posedge clk);
    rdc(OFS_CONTROL_STATUS, 32'h0);
    pulse;
    poll(3);
    chk(rd, 32'h8);
    wr(OFS_CONTROL_STATUS, 8'h01);
    rdc(OFS_CONTROL_STATUS, 32'h8);
    wr(OFS_CONTROL_STATUS, 8'h0e);
    rdc(OFS_CONTROL_STATUS, 32'h0);
    chk(32'(irq_ic), 32'h0);
    wr(OFS_CONFIGURATION, 8'h00);
    wr(OFS_CONTROL_STATUS, 8'h01);
    chk(32'(en), 32'h0);
  endtask

  // Hang guard: the whole run needs under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_sim;
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_level;
    t_compare;
    t_lowpower;
    end_sim;
  end
endmodule
